//--- logic/byte_buffer.sv
`timescale 1ns/1ps
`default_nettype none

module byte_buffer #(
	parameter int W = 8,
	parameter int DEPTH = 2
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	stream_if.sink push,
	stream_if.source pop
);
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0] mem_q [DEPTH];
	logic [CW-1:0] count_q;
	logic push_fire;
	logic pop_fire;
	logic [CW-1:0] wr_idx;

	generate
		if (DEPTH < 2 || W < 1) begin : g_bad
			$error("byte_buffer needs DEPTH >= 2 and W >= 1");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// head always sits in mem_q[0], so read data leave a flop
	assign push.ready = (count_q != CW'(DEPTH));
	assign pop.valid = (count_q != '0);
	assign pop.data = mem_q[0];
	assign push_fire = push.valid & push.ready;
	assign pop_fire = pop.valid & pop.ready;
	assign wr_idx = pop_fire ? count_q - CW'(1) : count_q;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			count_q <= '0;
		end else if (push_fire && !pop_fire) begin
			count_q <= count_q + CW'(1);
		end else if (pop_fire && !push_fire) begin
			count_q <= count_q - CW'(1);
		end
	end

	always_ff @(posedge clk_in) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (pop_fire && i < DEPTH - 1) begin
				mem_q[i] <= mem_q[i + 1];
			end
			if (push_fire && wr_idx == CW'(i)) begin
				mem_q[i] <= push.data;
			end
		end
	end

endmodule : byte_buffer

`default_nettype wire

//--- logic/i2c_master_map.svh
`ifndef I2C_MASTER_MAP_SVH
`define I2C_MASTER_MAP_SVH

// control word fields
`define CTRL_ENABLE_BIT 15
`define CTRL_START_BIT 0
`define CTRL_EVENT_BITS 5

// status word fields
`define STAT_ACK_BIT 15
`define STAT_TX_ACTIVE_BIT 14
`define STAT_STOP_SEEN_BIT 4
`define STAT_START_SEEN_BIT 3
`define STAT_TX_FULL_BIT 0

// baud counter
`define BAUD_WIDTH_DEFAULT 12
`define BAUD_RELOAD_MIN 2

// byte framing
`define BYTE_BITS 8
`define LAST_DATA_IDX 7
`define ACK_IDX 8

// transmit buffer
`define TX_BUF_DEPTH 2

`endif

//--- logic/i2c_master_pkg.sv
package i2c_master_pkg;

	typedef enum logic [2:0] {
		ENG_IDLE,
		ENG_START_A,
		ENG_START_B,
		ENG_TX_LOW,
		ENG_TX_RISE,
		ENG_TX_HIGH,
		ENG_TX_FALL
	} engine_state_t;

	typedef logic [7:0] tx_byte_t;

endpackage : i2c_master_pkg

//--- logic/i2c_master_start_tx.sv
`include "i2c_master_map.svh"
`timescale 1ns/1ps
`default_nettype none

module i2c_master_start_tx #(
	parameter int BAUD_W = `BAUD_WIDTH_DEFAULT
) (
	input wire logic MCLK_IN,
	input wire logic RSTN_IN,
	input wire logic ENABLE_IN,
	input wire logic CTRL_WR_IN,
	input wire logic [`CTRL_EVENT_BITS-1:0] CTRL_EVENT_IN,
	input wire logic TX_WR_IN,
	input wire i2c_master_pkg::tx_byte_t TX_DATA_IN,
	input wire logic WCOL_CLR_IN,
	input wire logic [BAUD_W-1:0] BAUD_RELOAD_IN,
	input wire logic SERIAL_DATA_IN,
	input wire logic SERIAL_CLOCK_IN,
	output logic SERIAL_DATA_OUT,
	output logic SERIAL_DATA_OE_OUT,
	output logic SERIAL_CLOCK_OUT,
	output logic SERIAL_CLOCK_OE_OUT,
	output logic START_REQUEST_OUT,
	output logic TRANSMIT_FULL_OUT,
	output logic TRANSMIT_ACTIVE_OUT,
	output logic WRITE_COLLISION_OUT,
	output logic ACK_STATUS_OUT,
	output logic START_SEEN_OUT,
	output logic STOP_SEEN_OUT,
	output logic MASTER_INT_OUT
);
	import i2c_master_pkg::*;

	generate
		if (BAUD_W < 2) begin : g_bad
			$error("BAUD_W must be at least 2");
		end
	endgenerate

	engine_state_t state_q;
	engine_state_t state_d;
	logic [BAUD_W-1:0] cnt_q;
	logic [BAUD_W-1:0] reload;
	logic [3:0] bit_q;
	tx_byte_t shift_q;
	logic sda_oe_q;
	logic scl_oe_q;
	logic line_lvl_q;
	logic start_req_q;
	logic tx_full_q;
	logic tx_active_q;
	logic wcol_q;
	logic ack_q;
	logic start_seen_q;
	logic stop_seen_q;
	logic mint_q;
	logic sda_prev_q;
	logic scl_prev_q;

	logic run;
	logic busy;
	logic counting;
	logic tmo;
	logic load;
	logic scl_hi;
	logic scl_lo;
	logic last_bit;
	logic ctrl_take;
	logic tx_try;
	logic tx_collide;
	logic go_start;
	logic go_tx;
	logic start_done;
	logic byte_done;
	logic start_ev;
	logic stop_ev;

	stream_if #(.W(8)) push_s ();
	stream_if #(.W(8)) pop_s ();

	////////////////////////////////////////////////////////////////////
	// write acceptance

	// disabling acts as a synchronous clear of the whole block
	assign run = RSTN_IN & ENABLE_IN;
	assign busy = start_req_q | tx_active_q | tx_full_q;
	assign ctrl_take = CTRL_WR_IN & run & ~busy
		& (state_q == ENG_IDLE);
	assign tx_try = TX_WR_IN & run;
	// buffer stays full only while a byte is owed, so ready joins busy
	assign tx_collide = tx_try & (busy | ~push_s.ready);
	assign push_s.valid = tx_try & ~tx_collide;
	assign push_s.data = TX_DATA_IN;

	byte_buffer #(
		.W(8),
		.DEPTH(`TX_BUF_DEPTH)
	) u_tx_buf (
		.clk_in(MCLK_IN),
		.rst_n_in(run),
		.push(push_s),
		.pop(pop_s)
	);

	////////////////////////////////////////////////////////////////////
	// sequencing events

	// forbidden reloads are lifted to the least legal value
	assign reload = (BAUD_RELOAD_IN < BAUD_W'(`BAUD_RELOAD_MIN))
		? BAUD_W'(`BAUD_RELOAD_MIN) : BAUD_RELOAD_IN;
	assign counting = (state_q == ENG_START_A) | (state_q == ENG_START_B)
		| (state_q == ENG_TX_LOW) | (state_q == ENG_TX_HIGH);
	assign tmo = counting & (cnt_q == '0);
	assign scl_hi = SERIAL_CLOCK_IN;
	assign scl_lo = ~SERIAL_CLOCK_IN;
	assign last_bit = (bit_q == 4'(`ACK_IDX));
	assign go_start = (state_q == ENG_IDLE) & start_req_q;
	assign go_tx = (state_q == ENG_IDLE) & ~start_req_q & pop_s.valid;
	assign pop_s.ready = go_tx;
	assign start_done = (state_q == ENG_START_B) & tmo;
	assign byte_done = (state_q == ENG_TX_FALL) & scl_lo & last_bit;
	// the wait state costs one cycle, giving reload+2 per half period
	assign load = go_start | go_tx
		| ((state_q == ENG_START_A) & tmo)
		| ((state_q == ENG_TX_RISE) & scl_hi)
		| ((state_q == ENG_TX_FALL) & scl_lo & ~last_bit);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ENG_IDLE: begin
				if (go_start) begin
					state_d = ENG_START_A;
				end else if (go_tx) begin
					state_d = ENG_TX_LOW;
				end
			end
			ENG_START_A: begin
				if (tmo) begin
					state_d = ENG_START_B;
				end
			end
			ENG_START_B: begin
				if (tmo) begin
					state_d = ENG_IDLE;
				end
			end
			ENG_TX_LOW: begin
				if (tmo) begin
					state_d = ENG_TX_RISE;
				end
			end
			ENG_TX_RISE: begin
				// a stretching slave holds us here
				if (scl_hi) begin
					state_d = ENG_TX_HIGH;
				end
			end
			ENG_TX_HIGH: begin
				if (tmo) begin
					state_d = ENG_TX_FALL;
				end
			end
			ENG_TX_FALL: begin
				if (scl_lo) begin
					state_d = last_bit ? ENG_IDLE : ENG_TX_LOW;
				end
			end
		endcase
	end

	always_ff @(posedge MCLK_IN) begin
		if (!run) begin
			state_q <= ENG_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge MCLK_IN) begin
		if (!run) begin
			cnt_q <= '0;
		end else if (load) begin
			cnt_q <= reload;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - BAUD_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////
	// data path

	always_ff @(posedge MCLK_IN) begin
		if (!run) begin
			shift_q <= '0;
			bit_q <= '0;
		end else if (go_tx) begin
			shift_q <= pop_s.data;
			bit_q <= '0;
		end else if ((state_q == ENG_TX_FALL) & scl_lo & ~last_bit) begin
			shift_q <= {shift_q[6:0], 1'b0};
			bit_q <= bit_q + 4'(1);
		end
	end

	////////////////////////////////////////////////////////////////////
	// line drivers: open drain, enable high pulls low

	always_ff @(posedge MCLK_IN) begin
		line_lvl_q <= 1'b0;
	end

	always_ff @(posedge MCLK_IN) begin
		if (!run) begin
			sda_oe_q <= 1'b0;
		end else if (go_tx) begin
			sda_oe_q <= ~pop_s.data[7];
		end else if ((state_q == ENG_START_A) & tmo) begin
			sda_oe_q <= 1'b1;
		end else if ((state_q == ENG_TX_FALL) & scl_lo & ~last_bit) begin
			if (bit_q == 4'(`LAST_DATA_IDX)) begin
				sda_oe_q <= 1'b0;
			end else begin
				sda_oe_q <= ~shift_q[6];
			end
		end
	end

	always_ff @(posedge MCLK_IN) begin
		if (!run) begin
			scl_oe_q <= 1'b0;
		end else if (start_done) begin
			scl_oe_q <= 1'b1;
		end else if ((state_q == ENG_TX_LOW) & tmo) begin
			scl_oe_q <= 1'b0;
		end else if ((state_q == ENG_TX_HIGH) & tmo) begin
			scl_oe_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// flags

	always_ff @(posedge MCLK_IN) begin
		if (!run) begin
			start_req_q <= 1'b0;
		end else if (start_done) begin
			start_req_q <= 1'b0;
		end else if (ctrl_take && CTRL_EVENT_IN[`CTRL_START_BIT]) begin
			start_req_q <= 1'b1;
		end
	end

	always_ff @(posedge MCLK_IN) begin
		if (!run) begin
			tx_full_q <= 1'b0;
		end else if (push_s.valid) begin
			tx_full_q <= 1'b1;
		end else if ((state_q == ENG_TX_FALL) & scl_lo
				& (bit_q == 4'(`LAST_DATA_IDX))) begin
			tx_full_q <= 1'b0;
		end
	end

	always_ff @(posedge MCLK_IN) begin
		if (!run) begin
			tx_active_q <= 1'b0;
		end else if (go_tx) begin
			tx_active_q <= 1'b1;
		end else if (byte_done) begin
			tx_active_q <= 1'b0;
		end
	end

	// set beats a clear arriving in the same cycle
	always_ff @(posedge MCLK_IN) begin
		if (!run) begin
			wcol_q <= 1'b0;
		end else if (tx_collide) begin
			wcol_q <= 1'b1;
		end else if (WCOL_CLR_IN) begin
			wcol_q <= 1'b0;
		end
	end

	// sampled just before the ninth falling edge is driven
	always_ff @(posedge MCLK_IN) begin
		if (!run) begin
			ack_q <= 1'b0;
		end else if ((state_q == ENG_TX_HIGH) & tmo & last_bit) begin
			ack_q <= SERIAL_DATA_IN;
		end
	end

	always_ff @(posedge MCLK_IN) begin
		if (!run) begin
			mint_q <= 1'b0;
		end else begin
			mint_q <= start_done | byte_done;
		end
	end

	////////////////////////////////////////////////////////////////////
	// bus monitor

	assign start_ev = scl_prev_q & SERIAL_CLOCK_IN
		& sda_prev_q & ~SERIAL_DATA_IN;
	assign stop_ev = scl_prev_q & SERIAL_CLOCK_IN
		& ~sda_prev_q & SERIAL_DATA_IN;

	always_ff @(posedge MCLK_IN) begin
		if (!run) begin
			sda_prev_q <= 1'b1;
			scl_prev_q <= 1'b1;
		end else begin
			sda_prev_q <= SERIAL_DATA_IN;
			scl_prev_q <= SERIAL_CLOCK_IN;
		end
	end

	always_ff @(posedge MCLK_IN) begin
		if (!run) begin
			start_seen_q <= 1'b0;
			stop_seen_q <= 1'b0;
		end else if (start_ev) begin
			start_seen_q <= 1'b1;
			stop_seen_q <= 1'b0;
		end else if (stop_ev) begin
			start_seen_q <= 1'b0;
			stop_seen_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs

	assign SERIAL_DATA_OUT = line_lvl_q;
	assign SERIAL_DATA_OE_OUT = sda_oe_q;
	assign SERIAL_CLOCK_OUT = line_lvl_q;
	assign SERIAL_CLOCK_OE_OUT = scl_oe_q;
	assign START_REQUEST_OUT = start_req_q;
	assign TRANSMIT_FULL_OUT = tx_full_q;
	assign TRANSMIT_ACTIVE_OUT = tx_active_q;
	assign WRITE_COLLISION_OUT = wcol_q;
	assign ACK_STATUS_OUT = ack_q;
	assign START_SEEN_OUT = start_seen_q;
	assign STOP_SEEN_OUT = stop_seen_q;
	assign MASTER_INT_OUT = mint_q;

endmodule : i2c_master_start_tx

`default_nettype wire

//--- logic/stream_if.sv
`timescale 1ns/1ps
`default_nettype none

interface stream_if #(
	parameter int W = 8
);
	logic valid;
	logic ready;
	logic [W-1:0] data;

	modport source (
		output valid,
		output data,
		input ready
	);

	modport sink (
		input valid,
		input data,
		output ready
	);

endinterface : stream_if

`default_nettype wire

//--- tb/bus_slave_model.sv
`timescale 1ns/1ps
`default_nettype none

module bus_slave_model (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic nack_in,
	input wire logic [4:0] stretch_in,
	output logic sda_oe_out,
	output logic scl_oe_out,
	output logic [7:0] rx_byte_out
);
	logic scl_d, sda_d;
	logic [3:0] n_q;
	logic [7:0] sh_q;
	logic [4:0] st_q;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			n_q <= 4'h0;
			sh_q <= 8'h00;
			st_q <= 5'h00;
			sda_oe_out <= 1'b0;
			scl_oe_out <= 1'b0;
			rx_byte_out <= 8'h00;
		end else begin
			scl_d <= scl_in;
			sda_d <= sda_in;
			if (st_q != 5'h00) begin
				st_q <= st_q - 5'h01;
				if (st_q == 5'h01) begin
					scl_oe_out <= 1'b0;
				end
			end
			if (scl_in && scl_d && sda_d && !sda_in) begin
				n_q <= 4'h0;
			end else if (scl_in && !scl_d) begin
				if (n_q < 4'h8) begin
					sh_q <= {sh_q[6:0], sda_in};
				end
				n_q <= n_q + 4'h1;
			end else if (!scl_in && scl_d) begin
				// hold clock low after each fall to stretch the bit
				st_q <= stretch_in;
				scl_oe_out <= (stretch_in != 5'h00);
				if (n_q == 4'h8) begin
					sda_oe_out <= !nack_in;
					rx_byte_out <= sh_q;
				end
				if (n_q == 4'h9) begin
					sda_oe_out <= 1'b0;
					n_q <= 4'h0;
				end
			end
		end
	end
endmodule : bus_slave_model

`default_nettype wire

//--- tb/i2c_start_tx_assertions.sv
`include "i2c_master_map.svh"
`timescale 1ns/1ps
`default_nettype none

module i2c_start_tx_assertions #(
	parameter int BAUD_W = `BAUD_WIDTH_DEFAULT
) (
	input wire logic MCLK_IN,
	input wire logic RSTN_IN,
	input wire logic ENABLE_IN,
	input wire logic CTRL_WR_IN,
	input wire logic [`CTRL_EVENT_BITS-1:0] CTRL_EVENT_IN,
	input wire logic TX_WR_IN,
	input wire logic WCOL_CLR_IN,
	input wire logic [BAUD_W-1:0] BAUD_RELOAD_IN,
	input wire logic SERIAL_DATA_IN,
	input wire logic SERIAL_CLOCK_IN,
	input wire logic SERIAL_DATA_OE_OUT,
	input wire logic SERIAL_CLOCK_OE_OUT,
	input wire logic START_REQUEST_OUT,
	input wire logic TRANSMIT_FULL_OUT,
	input wire logic TRANSMIT_ACTIVE_OUT,
	input wire logic WRITE_COLLISION_OUT,
	input wire logic ACK_STATUS_OUT,
	input wire logic MASTER_INT_OUT
);
	default clocking cb @(posedge MCLK_IN);
	endclocking
	default disable iff (!RSTN_IN);

	logic busy;
	logic [BAUD_W:0] gap_q;
	assign busy = START_REQUEST_OUT || TRANSMIT_FULL_OUT || TRANSMIT_ACTIVE_OUT;

	// cycles with data already low while the start is still pending
	always_ff @(posedge MCLK_IN) begin
		if (!RSTN_IN) begin
			gap_q <= '0;
		end else begin
			gap_q <= (START_REQUEST_OUT && SERIAL_DATA_OE_OUT) ? gap_q + 1'b1 : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	int_pulse_a: assert property (MASTER_INT_OUT |=> !MASTER_INT_OUT)
		else $error("interrupt longer than one cycle");
	off_released_a: assert property (!ENABLE_IN |=> !SERIAL_DATA_OE_OUT && !SERIAL_CLOCK_OE_OUT)
		else $error("bus driven while disabled");
	start_gap_a: assert property ($fell(START_REQUEST_OUT) && ENABLE_IN |-> MASTER_INT_OUT && SERIAL_CLOCK_OE_OUT && gap_q == {1'b0, BAUD_RELOAD_IN} + 1'b1)
		else $error("start end timing wrong");
	tx_full_a: assert property (TX_WR_IN && ENABLE_IN && !busy |=> TRANSMIT_FULL_OUT)
		else $error("transmit full not set");
	wcol_set_a: assert property (TX_WR_IN && ENABLE_IN && busy |=> WRITE_COLLISION_OUT)
		else $error("collision not flagged");
	wcol_hold_a: assert property (WRITE_COLLISION_OUT && ENABLE_IN && !WCOL_CLR_IN |=> WRITE_COLLISION_OUT)
		else $error("collision flag lost");
	ctrl_lock_a: assert property (CTRL_WR_IN && CTRL_EVENT_IN[0] && (TRANSMIT_FULL_OUT || TRANSMIT_ACTIVE_OUT) |=> !START_REQUEST_OUT)
		else $error("start taken during transmit");
	bit_change_a: assert property ($changed(SERIAL_DATA_OE_OUT) && TRANSMIT_FULL_OUT && $past(TRANSMIT_ACTIVE_OUT) |-> SERIAL_CLOCK_OE_OUT && !$past(SERIAL_CLOCK_IN))
		else $error("data changed with clock high");
	ack_rel_a: assert property ($fell(TRANSMIT_FULL_OUT) && ENABLE_IN |-> !SERIAL_DATA_OE_OUT && SERIAL_CLOCK_OE_OUT)
		else $error("data not released after eighth bit");
	ack_sample_a: assert property ($changed(ACK_STATUS_OUT) && ENABLE_IN && $past(ENABLE_IN) |-> ACK_STATUS_OUT == $past(SERIAL_DATA_IN) && $rose(SERIAL_CLOCK_OE_OUT))
		else $error("ack status off its sample");
	tx_end_a: assert property ($fell(TRANSMIT_ACTIVE_OUT) && ENABLE_IN |-> MASTER_INT_OUT && SERIAL_CLOCK_OE_OUT)
		else $error("byte end wrong");

	start_done_c: cover property ($fell(START_REQUEST_OUT));
	nack_c: cover property ($fell(TRANSMIT_ACTIVE_OUT) && ACK_STATUS_OUT);
	wcol_c: cover property ($rose(WRITE_COLLISION_OUT));
endmodule : i2c_start_tx_assertions

bind i2c_master_start_tx i2c_start_tx_assertions #(.BAUD_W(BAUD_W)) chk (
	.MCLK_IN(MCLK_IN), .RSTN_IN(RSTN_IN), .ENABLE_IN(ENABLE_IN),
	.CTRL_WR_IN(CTRL_WR_IN), .CTRL_EVENT_IN(CTRL_EVENT_IN),
	.TX_WR_IN(TX_WR_IN), .WCOL_CLR_IN(WCOL_CLR_IN),
	.BAUD_RELOAD_IN(BAUD_RELOAD_IN), .SERIAL_DATA_IN(SERIAL_DATA_IN),
	.SERIAL_CLOCK_IN(SERIAL_CLOCK_IN),
	.SERIAL_DATA_OE_OUT(SERIAL_DATA_OE_OUT),
	.SERIAL_CLOCK_OE_OUT(SERIAL_CLOCK_OE_OUT),
	.START_REQUEST_OUT(START_REQUEST_OUT),
	.TRANSMIT_FULL_OUT(TRANSMIT_FULL_OUT),
	.TRANSMIT_ACTIVE_OUT(TRANSMIT_ACTIVE_OUT),
	.WRITE_COLLISION_OUT(WRITE_COLLISION_OUT),
	.ACK_STATUS_OUT(ACK_STATUS_OUT), .MASTER_INT_OUT(MASTER_INT_OUT)
);

`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import i2c_master_pkg::*;
	localparam logic [11:0] RLD = 12'h003;
	logic mclk = 1'b0, rstn = 1'b0, en = 1'b0, cwr = 1'b0, twr = 1'b0;
	logic wclr = 1'b0, nack = 1'b0, scl_prev = 1'b1;
	logic [4:0] cev = 5'h00, stretch = 5'h00;
	tx_byte_t tdat = 8'h00, rx_byte;
	logic sda_oe, scl_oe, s_sda_oe, s_scl_oe;
	logic req, full, act, wcol, ack, sseen, pseen, mint, sda_lvl, scl_lvl;
	wire sda_w = ~(sda_oe | s_sda_oe);
	wire scl_w = ~(scl_oe | s_scl_oe);
	int errors = 0, check_count = 0, cyc = 0, last_rise = 0, per = 0;

	always #50 mclk = ~mclk;
	// period of the last clock pulse on the wire
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		scl_prev <= scl_w;
		if (scl_w && !scl_prev) begin
			per <= cyc - last_rise;
			last_rise <= cyc;
		end
	end

	i2c_master_start_tx uut (.MCLK_IN(mclk), .RSTN_IN(rstn), .ENABLE_IN(en),
		.CTRL_WR_IN(cwr), .CTRL_EVENT_IN(cev), .TX_WR_IN(twr),
		.TX_DATA_IN(tdat), .WCOL_CLR_IN(wclr), .BAUD_RELOAD_IN(RLD),
		.SERIAL_DATA_IN(sda_w), .SERIAL_CLOCK_IN(scl_w),
		.SERIAL_DATA_OUT(sda_lvl), .SERIAL_DATA_OE_OUT(sda_oe),
		.SERIAL_CLOCK_OUT(scl_lvl), .SERIAL_CLOCK_OE_OUT(scl_oe),
		.START_REQUEST_OUT(req), .TRANSMIT_FULL_OUT(full),
		.TRANSMIT_ACTIVE_OUT(act), .WRITE_COLLISION_OUT(wcol),
		.ACK_STATUS_OUT(ack), .START_SEEN_OUT(sseen),
		.STOP_SEEN_OUT(pseen), .MASTER_INT_OUT(mint));
	bus_slave_model slave (.clk_in(mclk), .rst_n_in(rstn), .scl_in(scl_w),
		.sda_in(sda_w), .nack_in(nack), .stretch_in(stretch),
		.sda_oe_out(s_sda_oe), .scl_oe_out(s_scl_oe), .rx_byte_out(rx_byte));

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : finish_test

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick

	task automatic wait_int();
		for (int i = 0; i < 3000 && mint !== 1'b1; i++) tick(1);
		if (mint !== 1'b1) begin
			errors++;
			$display("MISMATCH t=%0t no interrupt", $time);
			finish_test();
		end
	endtask : wait_int

	task automatic ctrl(input logic [4:0] v);
		cev = v;
		cwr = 1'b1;
		tick(1);
		cwr = 1'b0;
	endtask : ctrl

	task automatic txw(input tx_byte_t b);
		tdat = b;
		twr = 1'b1;
		tick(1);
		twr = 1'b0;
	endtask : txw

	// wait for the byte end and compare what the slave saw
	task automatic done(input tx_byte_t b, input logic nk);
		wait_int();
		check(ack, nk);
		check(rx_byte, b);
		check({act, scl_oe}, 8'h01);
	endtask : done

	task automatic send(input tx_byte_t b, input logic nk);
		nack = nk;
		txw(b);
		done(b, nk);
	endtask : send

	initial begin
		tick(10);
		rstn = 1'b1;
		en = 1'b1;
		tick(1);
		check({req, full, act, wcol, ack, sda_oe, scl_oe}, 8'h00);
		$display("test reset done");
		check(pseen, 1'b0);
		ctrl(5'h01);
		check(req, 1'b1);
		txw(8'h77);
		check(wcol, 1'b1);
		ctrl(5'h00);
		check(req, 1'b1);
		wait_int();
		check({sseen, pseen, req}, 8'h04);
		check({sda_oe, scl_oe, full}, 8'h06);
		check({sda_lvl, scl_lvl}, 8'h00);
		wclr = 1'b1;
		tick(1);
		wclr = 1'b0;
		check(wcol, 1'b0);
		$display("test start done");
		nack = 1'b0;
		txw(8'ha0);
		check(full, 1'b1);
		tick(20);
		txw(8'hff);
		check(wcol, 1'b1);
		ctrl(5'h01);
		check(req, 1'b0);
		done(8'ha0, 1'b0);
		check(8'(per), 8'(2 * (RLD + 2)));
		check(wcol, 1'b1);
		$display("test address done");
		send(8'hf2, 1'b0);
		send(8'h34, 1'b1);
		send(8'h5a, 1'b0);
		$display("test long address done");
		stretch = 5'h0c;
		send(8'ha5, 1'b1);
		stretch = 5'h00;
		$display("test stretch done");
		en = 1'b0;
		tick(1);
		check({sda_oe, scl_oe, wcol, ack}, 8'h00);
		ctrl(5'h01);
		check(req, 1'b0);
		$display("test disable done");
		finish_test();
	end
endmodule : tb_top

`default_nettype wire
